// file: rtl/cfg_regs_pkg.sv
// constants for the configuration status and class register bank
// assumes byte-wide configuration access with byte addresses 00h..FFh
package cfg_regs_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // byte offsets of the mapped locations
  localparam logic [7:0] OFF_STATUS_LO    = 8'h06;
  localparam logic [7:0] OFF_STATUS_HI    = 8'h07;
  localparam logic [7:0] OFF_REVISION     = 8'h08;
  localparam logic [7:0] OFF_CAT_MINOR    = 8'h0A;
  localparam logic [7:0] OFF_CAT_MAJOR    = 8'h0B;
  localparam logic [7:0] OFF_HEADER       = 8'h0E;
  localparam logic [7:0] OFF_VENDOR_TAG_LO = 8'h2C;
  localparam logic [7:0] OFF_VENDOR_TAG_HI = 8'h2D;

  // status word field positions
  localparam int unsigned ST_PARITY_DETECTED  = 15;
  localparam int unsigned ST_SYSTEM_ERROR     = 14;
  localparam int unsigned ST_MASTER_ABORT     = 13;
  localparam int unsigned ST_TARGET_ABORT_RX  = 12;
  localparam int unsigned ST_TARGET_ABORT_TX  = 11;
  localparam int unsigned ST_SEL_TIMING_HI    = 10;
  localparam int unsigned ST_SEL_TIMING_LO    = 9;
  localparam int unsigned ST_MASTER_PARITY    = 8;
  localparam int unsigned ST_BACK_TO_BACK     = 7;
  localparam int unsigned ST_CAP_LIST         = 4;

  // fixed values and values after reset
  localparam logic [15:0] STATUS_RESET       = 16'h0080;
  localparam logic [1:0]  SEL_TIMING_FAST    = 2'h0;
  localparam logic [7:0]  CAT_MINOR_VALUE    = 8'h80;
  localparam logic [7:0]  CAT_MAJOR_VALUE    = 8'h08;
  localparam logic [7:0]  HEADER_MULTI_FUNC  = 8'h80;
  localparam logic [7:0]  HEADER_SINGLE_FUNC = 8'h00;
  localparam logic [15:0] VENDOR_TAG_RESET   = 16'h0000;
  localparam logic [7:0]  UNMAPPED_READ      = 8'h00;

  // pin synchroniser depth and its value after reset (functions enabled)
  localparam int unsigned SYNC_STAGES        = 3;
  localparam logic [2:0]  SYNC_RESET         = 3'h7;

  // registered state of the bank
  typedef struct packed {
    logic [2:0] fn_sync;     // pin synchroniser, [0] is the first stage
    logic       fn_en;       // debounced function-enable level
    logic [7:0] rdata;       // read answer, valid for one cycle
    logic       single_fn;   // header reports a single function
  } cfg_state_t;

endpackage : cfg_regs_pkg

// file: rtl/wo_reg_if.sv
// carrier between the bank and one write-once byte store
// assumes both ends share clk and resetn
`timescale 1ns/1ps
interface wo_reg_if #(
  parameter int unsigned WIDTH = 8
);
  logic             wr_en;   // one-cycle write request
  logic [WIDTH-1:0] wdata;   // data offered with wr_en
  logic [WIDTH-1:0] value;   // stored value
  logic             locked;  // first write has happened

  modport owner (output wr_en, output wdata, input value, input locked);
  modport store (input wr_en, input wdata, output value, output locked);
endinterface : wo_reg_if

// file: rtl/write_once_reg.sv
// one write-once storage byte: the first write lands, later ones are dropped
// assumes wr_en is a one-cycle pulse on clk; lock holds until resetn
`timescale 1ns/1ps
module write_once_reg
  import cfg_regs_pkg::*;
#(
  parameter int unsigned    WIDTH       = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic clk,
  input  wire logic resetn,
  wo_reg_if.store   port
);

  typedef struct packed {
    logic [WIDTH-1:0] value;
    logic             locked;
  } wo_state_t;

  wo_state_t state_q;
  wo_state_t state_d;

  // accept only while unlocked; the accepting write also sets the lock
  always_comb begin
    state_d = state_q;
    if (port.wr_en && !state_q.locked) begin
      state_d.value  = port.wdata;
      state_d.locked = 1'b1;
    end
  end

  // lock clears only on reset, never by software
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q.value  <= RESET_VALUE;
      state_q.locked <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign port.value  = state_q.value;
  assign port.locked = state_q.locked;

endmodule : write_once_reg

// file: rtl/cfg_status_and_class_regs.sv
// configuration header bank: status word, revision, class codes,
// header layout and the write-once board vendor tag
// assumes a byte-wide configuration port on clk; the function-enable
// level arrives asynchronously from a pin or strap
//
// How it works
// - error status bits 15,14,13,12,11 and 8 read zero; writes dropped
// - select timing field 10:9 always reads 00; writes leave it alone
// - status bit 7 reads one for back-to-back capability; writes dropped
// - status bit 4 reads zero: no capability list offered
// - status word reads 0080h from reset onward
// - all status bits read-only; bit 14 write-clear but still reads zero
// - eight-bit revision byte is read-only; writes to it are discarded
// - minor category byte always reads 80h
// - major category byte always reads 08h
// - header byte reads 80 while the further functions are enabled
// - header byte reads 00 when only function zero remains enabled
// - header derived from enable state, no storage, no access side effects
// - each vendor tag byte takes its own first write, then stays read-only until reset
// - vendor tag reads 0000h after reset until written
`timescale 1ns/1ps
module cfg_status_and_class_regs
  import cfg_regs_pkg::*;
#(
  parameter logic [7:0] REVISION_VALUE = 8'h5A  // arbitrary value
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              other_functions_en,
  output logic      [15:0]       board_vendor_tag,
  output logic                   vendor_tag_lo_locked,
  output logic                   vendor_tag_hi_locked,
  output logic                   single_function
);

  cfg_state_t state_q;
  cfg_state_t state_d;

  // carriers to the two write-once bytes of the vendor tag
  wo_reg_if #(.WIDTH(8)) tag_lo ();
  wo_reg_if #(.WIDTH(8)) tag_hi ();

  // status word assembled from constants; nothing here is stored
  logic [15:0] pci_status_word;
  logic        parity_detected_flag;
  logic        system_error_sent_flag;
  logic        master_abort_seen_flag;
  logic        target_abort_seen_flag;
  logic        target_abort_sent_flag;
  logic [1:0]  select_timing_code;
  logic        master_parity_flag;
  logic        back_to_back_capable;
  logic        capability_list_present;

  // per-location decode of the current address
  logic        hit_status_lo;
  logic        hit_status_hi;
  logic        hit_revision;
  logic        hit_cat_minor;
  logic        hit_cat_major;
  logic        hit_header;
  logic        hit_tag_lo;
  logic        hit_tag_hi;

  // byte views and derived header value
  logic [7:0]  silicon_revision;
  logic [7:0]  function_category_minor;
  logic [7:0]  function_category_major;
  logic [7:0]  header_layout;
  logic [7:0]  read_mux;

  // bit-14 write-one-to-clear request; kept visible but has no target
  logic        sse_clear_req;

  // no error path exists in this function, so every error flag is tied low
  always_comb begin
    parity_detected_flag    = 1'b0;
    system_error_sent_flag  = 1'b0;
    master_abort_seen_flag  = 1'b0;
    target_abort_seen_flag  = 1'b0;
    target_abort_sent_flag  = 1'b0;
    master_parity_flag      = 1'b0;
    select_timing_code      = SEL_TIMING_FAST;
    back_to_back_capable    = 1'b1;
    capability_list_present = 1'b0;
  end

  // pack the status word; reserved positions stay zero
  always_comb begin
    pci_status_word                      = '0;
    pci_status_word[ST_PARITY_DETECTED]  = parity_detected_flag;
    pci_status_word[ST_SYSTEM_ERROR]     = system_error_sent_flag;
    pci_status_word[ST_MASTER_ABORT]     = master_abort_seen_flag;
    pci_status_word[ST_TARGET_ABORT_RX]  = target_abort_seen_flag;
    pci_status_word[ST_TARGET_ABORT_TX]  = target_abort_sent_flag;
    pci_status_word[ST_SEL_TIMING_HI]    = select_timing_code[1];
    pci_status_word[ST_SEL_TIMING_LO]    = select_timing_code[0];
    pci_status_word[ST_MASTER_PARITY]    = master_parity_flag;
    pci_status_word[ST_BACK_TO_BACK]     = back_to_back_capable;
    pci_status_word[ST_CAP_LIST]         = capability_list_present;
  end

  // fixed identity and class bytes
  always_comb begin
    silicon_revision        = REVISION_VALUE;
    function_category_minor = CAT_MINOR_VALUE;
    function_category_major = CAT_MAJOR_VALUE;
  end

  // header follows the debounced enable level with no storage of its own;
  // decoding it cannot disturb anything, so reads and writes are harmless
  always_comb begin
    if (state_q.fn_en) begin
      header_layout = HEADER_MULTI_FUNC;
    end else begin
      header_layout = HEADER_SINGLE_FUNC;
    end
  end

  // address decode, one hit per mapped byte
  always_comb begin
    hit_status_lo = (addr == OFF_STATUS_LO);
    hit_status_hi = (addr == OFF_STATUS_HI);
    hit_revision  = (addr == OFF_REVISION);
    hit_cat_minor = (addr == OFF_CAT_MINOR);
    hit_cat_major = (addr == OFF_CAT_MAJOR);
    hit_header    = (addr == OFF_HEADER);
    hit_tag_lo    = (addr == OFF_VENDOR_TAG_LO);
    hit_tag_hi    = (addr == OFF_VENDOR_TAG_HI);
  end

  // writes: only the vendor tag bytes accept data; every other mapped
  // byte is read-only and a write there changes nothing
  always_comb begin
    tag_lo.wr_en = wr && hit_tag_lo;
    tag_hi.wr_en = wr && hit_tag_hi;
    tag_lo.wdata = wdata;
    tag_hi.wdata = wdata;
  end

  // a one written to bit 14 would clear it, but the bit is tied low, so the
  // request is decoded and deliberately goes nowhere
  always_comb begin
    sse_clear_req = wr && hit_status_hi && wdata[ST_SYSTEM_ERROR - 8];
  end

  // read multiplexer; unmapped bytes read zero
  always_comb begin
    read_mux = UNMAPPED_READ;
    if (hit_status_lo) begin
      read_mux = pci_status_word[7:0];
    end else if (hit_status_hi) begin
      read_mux = pci_status_word[15:8];
    end else if (hit_revision) begin
      read_mux = silicon_revision;
    end else if (hit_cat_minor) begin
      read_mux = function_category_minor;
    end else if (hit_cat_major) begin
      read_mux = function_category_major;
    end else if (hit_header) begin
      read_mux = header_layout;
    end else if (hit_tag_lo) begin
      read_mux = tag_lo.value;
    end else if (hit_tag_hi) begin
      read_mux = tag_hi.value;
    end
  end

  // next state: synchroniser, debounce, read answer
  always_comb begin
    state_d = state_q;
    // shift the pin through three stages; stage 0 feeds only stage 1
    state_d.fn_sync = {state_q.fn_sync[1:0], other_functions_en};
    // a change counts once the second and third stages agree
    if (state_q.fn_sync[1] == state_q.fn_sync[2]) begin
      state_d.fn_en = state_q.fn_sync[2];
    end
    state_d.single_fn = !state_d.fn_en;
    // read data stand only in the cycle after the strobe
    if (rd) begin
      state_d.rdata = read_mux;
    end else begin
      state_d.rdata = '0;
    end
  end

  // bank state except the vendor tag bytes in one register; the enable defaults to the multi
  // function view so the header reads 80h from reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q.fn_sync   <= SYNC_RESET;
      state_q.fn_en     <= 1'b1;
      state_q.rdata     <= '0;
      state_q.single_fn <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // low byte of the board vendor tag
  write_once_reg #(
    .WIDTH       (8),
    .RESET_VALUE (VENDOR_TAG_RESET[7:0])
  ) u_tag_lo (
    .clk    (clk),
    .resetn (resetn),
    .port   (tag_lo)
  );

  // high byte of the board vendor tag, locks on its own first write
  write_once_reg #(
    .WIDTH       (8),
    .RESET_VALUE (VENDOR_TAG_RESET[15:8])
  ) u_tag_hi (
    .clk    (clk),
    .resetn (resetn),
    .port   (tag_hi)
  );

  // outputs come straight from flip-flops here or in the byte stores
  assign rdata                = state_q.rdata;
  assign single_function      = state_q.single_fn;
  assign board_vendor_tag     = {tag_hi.value, tag_lo.value};
  assign vendor_tag_lo_locked = tag_lo.locked;
  assign vendor_tag_hi_locked = tag_hi.locked;

endmodule : cfg_status_and_class_regs

// file: verif/cfg_status_and_class_regs_sva.sv
// port-level assertions for the configuration status and class bank
// assumes one clock domain, async active-low reset, byte-wide port
`timescale 1ns/1ps
module cfg_status_and_class_regs_sva
  import cfg_regs_pkg::*;
#(
  parameter logic [7:0] REVISION_VALUE = 8'h5A
) (
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [15:0]       board_vendor_tag,
  input wire logic              vendor_tag_lo_locked,
  input wire logic              vendor_tag_hi_locked,
  input wire logic              single_function
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // fixed read answers, one cycle after the strobe
  AST_STS_LO: assert property (rd && addr == 8'h06 |=> rdata == 8'h80) else $error("status low byte wrong");
  AST_STS_HI: assert property (rd && addr == 8'h07 |=> rdata == 8'h00) else $error("status high byte wrong");
  AST_REV: assert property (rd && addr == 8'h08 |=> rdata == REVISION_VALUE) else $error("revision wrong");
  AST_MINOR: assert property (rd && addr == 8'h0A |=> rdata == 8'h80) else $error("minor category wrong");
  AST_MAJOR: assert property (rd && addr == 8'h0B |=> rdata == 8'h08) else $error("major category wrong");
  // header follows the enable view; only judged while that view is steady
  AST_HDR: assert property (rd && addr == 8'h0E ##1 $stable(single_function) |->
    rdata == (single_function ? 8'h00 : 8'h80)) else $error("header layout wrong");
  // first write to each tag byte lands and locks it
  AST_TAG_LO: assert property (wr && addr == 8'h2C && !vendor_tag_lo_locked |=>
    vendor_tag_lo_locked && board_vendor_tag[7:0] == $past(wdata)) else $error("tag low write lost");
  AST_TAG_HI: assert property (wr && addr == 8'h2D && !vendor_tag_hi_locked |=>
    vendor_tag_hi_locked && board_vendor_tag[15:8] == $past(wdata)) else $error("tag high write lost");
  AST_TAG_HOLD: assert property (vendor_tag_lo_locked && vendor_tag_hi_locked |=>
    $stable(board_vendor_tag) && vendor_tag_lo_locked) else $error("locked tag changed");
  AST_TAG_RST: assert property ($rose(resetn) |-> board_vendor_tag == 16'h0000) else $error("tag not cleared");
endmodule : cfg_status_and_class_regs_sva

bind cfg_status_and_class_regs cfg_status_and_class_regs_sva #(.REVISION_VALUE(REVISION_VALUE)) u_sva (
  .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .board_vendor_tag(board_vendor_tag), .vendor_tag_lo_locked(vendor_tag_lo_locked),
  .vendor_tag_hi_locked(vendor_tag_hi_locked), .single_function(single_function));

// file: verif/cfg_status_and_class_regs_tb_top.sv
// self-checking bench for the configuration bank with a behavioural model
// assumes the bank answers reads one cycle after the strobe
`timescale 1ns/1ps
module cfg_status_and_class_regs_tb_top
  import cfg_regs_pkg::*;
;
  localparam logic [7:0] REV = 8'hC3;  // arbitrary revision value
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        pin_en = 1'b1;
  logic [7:0]  rdata;
  logic [15:0] tag;
  logic        lo_lk;
  logic        hi_lk;
  logic        single_fn;
  int          err_total = 0;
  int          cmp_count = 0;
  int          seed = 67657;
  int          cyc = 0;
  int          m_tag, m_lo, m_hi, m_en;  // model state
  logic [7:0]  amap [$] = '{8'h06, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h0E, 8'h2C, 8'h2D, 8'h09, 8'h5F};

  cfg_status_and_class_regs #(.REVISION_VALUE(REV)) dut (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .other_functions_en(pin_en), .board_vendor_tag(tag), .vendor_tag_lo_locked(lo_lk),
    .vendor_tag_hi_locked(hi_lk), .single_function(single_fn));

  always #20 clk = ~clk;

  // hang guard: far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc >= 3000) begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask : check

  // model answer for a read; unmapped places read zero
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h06: return 8'h80;
      8'h08: return REV;
      8'h0A: return 8'h80;
      8'h0B: return 8'h08;
      8'h0E: return m_en ? 8'h80 : 8'h00;
      8'h2C: return 8'(m_tag);
      8'h2D: return 8'(m_tag >> 8);
      default: return 8'h00;
    endcase
  endfunction : exp_rd

  task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // write-once: only the first write per byte counts
    if (a == 8'h2C && m_lo == 0) begin
      m_tag = (m_tag & 32'h0000FF00) | int'(d);
      m_lo  = 1;
    end
    if (a == 8'h2D && m_hi == 0) begin
      m_tag = (m_tag & 32'h000000FF) | (int'(d) << 8);
      m_hi  = 1;
    end
  endtask : wr_b

  task automatic rd_b(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check($sformatf("read %h", a), {8'h00, exp_rd(a)}, {8'h00, rdata});
  endtask : rd_b

  // read every place, then the tag and status pins
  task automatic sweep();
    foreach (amap[i]) rd_b(amap[i]);
    check("tag", 16'(m_tag), tag);
    check("lo_lock", 16'(m_lo), {15'h0000, lo_lk});
    check("hi_lock", 16'(m_hi), {15'h0000, hi_lk});
    check("single", 16'(!m_en), {15'h0000, single_fn});
  endtask : sweep

  task automatic model_reset();
    m_tag = 0;
    m_lo  = 0;
    m_hi  = 0;
  endtask : model_reset

  initial begin
    model_reset();
    m_en = 1;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    sweep();
    wr_b(8'h07, 8'hFF);
    wr_b(8'h06, 8'hFF);
    // every listed place gets a random byte in two passes; only the first pass lands in the tag
    foreach (amap[i]) wr_b(amap[i], 8'($random(seed)));
    sweep();
    foreach (amap[i]) wr_b(amap[i], 8'($random(seed)));
    sweep();
    // pin change needs the synchroniser depth plus a little
    @(posedge clk);
    pin_en <= 1'b0;
    repeat (8) @(posedge clk);
    m_en = 0;
    sweep();
    @(posedge clk);
    pin_en <= 1'b1;
    repeat (8) @(posedge clk);
    m_en = 1;
    sweep();
    // second reset mid-run must unlock and clear the tag
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    model_reset();
    sweep();
    wr_b(8'h2D, 8'($random(seed)));
    wr_b(8'h2C, 8'($random(seed)));
    wr_b(8'h2C, 8'($random(seed)));
    sweep();
    conclude();
  end
endmodule : cfg_status_and_class_regs_tb_top
